// *** inc/sttlm_pkg.sv ***
/*
 Package for the serial transmitter test and lock monitor: register indices,
 field layouts, reset values, pattern rates and generator constants.
 Assumes a 32-bit APB master with 12-bit byte addresses, one word per register.
*/
package sttlm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_TX_CONFIG       = 8'h14;
    localparam logic [7:0]  IDX_LOCK_STATUS     = 8'h16;
    localparam logic [7:0]  IDX_LOCK_WAIT       = 8'h17;
    localparam logic [7:0]  IDX_TEST_CONTROL    = 8'h18;
    localparam logic [7:0]  IDX_TEST_CODES01    = 8'h19;
    localparam logic [7:0]  IDX_TEST_CODE2_FRC  = 8'h1A;
    localparam int          ADDR_W              = 12;
    localparam int          IDX_LSB             = 2;
    localparam int          IDX_MSB             = 9;
    localparam int          LOAD_EN_STATUS_BIT  = 12;
    localparam int          LOCK_FLAG_BIT       = 8;
    localparam int          LOCK_STATUS_BIT     = 9;
    localparam int          FORCE_HIGH_BIT      = 8;
    localparam int          FORCE_LOW_BIT       = 9;
    localparam logic [15:0] CTRL_WMASK          = 16'h7FFF;
    localparam logic [15:0] CODE2_WMASK         = 16'h03FF;
    localparam logic [15:0] REG_RESET           = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO           = 8'h00;
    localparam logic [7:0]  BYTE_ONE            = 8'h01;
    // Data path
    localparam int          LANE_W              = 8;
    localparam int          LANES               = 3;
    localparam int          WORD_W              = LANE_W * LANES;
    localparam int          SER_W               = 30;
    localparam logic [1:0]  PAD_ZERO            = 2'b00;
    // Pattern rate codes and word hold counts (clock cycles per word minus one)
    localparam logic [1:0]  RATE_1200           = 2'b00;
    localparam logic [1:0]  RATE_400            = 2'b01;
    localparam logic [1:0]  RATE_600            = 2'b10;
    localparam logic [1:0]  RATE_RESET          = 2'b11;
    localparam logic [1:0]  HOLD_1200           = 2'd0;
    localparam logic [1:0]  HOLD_400            = 2'd2;
    localparam logic [1:0]  HOLD_600            = 2'd1;
    localparam logic [6:0]  PRBS_SEED           = 7'h7F;
    localparam int          PRBS_TAP_A          = 6;
    localparam int          PRBS_TAP_B          = 5;

    typedef struct packed {
        logic       unused;
        logic [2:0] ctrl_sym_sel;   // lane2..lane0
        logic [1:0] lane2_pad_bits;
        logic [1:0] lane1_pad_bits;
        logic [1:0] lane0_pad_bits;
        logic       bypass;
        logic [1:0] rate;
        logic       single_lane;
        logic       prbs_sel;
        logic       test_en;
    } sttlm_ctrl_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } sttlm_apb_req_t;

    typedef enum logic {UNLOCKED_STATE, LOCKED_STATE} sttlm_lock_t;
endpackage : sttlm_pkg

// *** verilog/sttlm_top.sv ***
/*
 Test and control logic ahead of the serial transmitter: lock monitor, load
 enable control, test pattern multiplexer with PRBS-7 source, APB registers.
 Assumes pll_lock_raw and all data inputs are synchronous to clk_sys; the
 encoder and serializer sit outside and take the registered words.
*/
// Design decision made here: register access over APB.
// How it works
// - Lock only after raw lock seen high for lock wait cycles
// - Unlock only after raw lock seen low for unlock wait cycles
// - Test enable feeds test words and cuts off the data unit
// - Pattern select: 0 constant codes, 1 PRBS-7 words
// - Single lane bit works only in test mode, gives 400 Mb/s
// - Outer module master forces single lane regardless of the bit
// - Rate field: 00 1200, 01 400, 10 600 Mb/s
// - Rate 11 holds the PRBS generator in synchronous reset
// - Rate field acts only in test mode with PRBS selected
// - Bypass bit sends words straight to serializer, test mode or not
// - Two-bit pads extend constant codes when bypassed without PRBS
// - Control bits 12..14 drive lane 0..2 control symbol selects
// - Test codes go constantly to lanes 0, 1, 2 without PRBS
// - Normally load enable equals locked status
// - Force high bit holds load enable high
// - Force low bit holds load enable low, beats force high
// - Low load enable keeps serializer in reset
// - Force low sends PLL clock replica to the output
// - Lock counter counts entries into the locked state
// - Status bit shows current load enable level
// - Locked status high exactly in the locked state
`timescale 1ns/1ps
`default_nettype none
module sttlm_top (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    // APB slave
    input  wire sttlm_pkg::sttlm_apb_req_t  apb_req,
    output logic                            pready,
    output logic                            pslverr,
    output logic [31:0]                     prdata,
    // PLL and chip configuration
    input  wire logic                       pll_lock_raw,
    input  wire logic                       outer_master,
    // Data handling unit word
    input  wire logic [23:0]                data_unit_word,
    // Encoder and serializer side
    output logic [23:0]                     enc_word,
    output logic [2:0]                      enc_ctrl_sym_sel,
    output logic                            enc_bypass,
    output logic [29:0]                     ser_raw_word,
    output logic                            single_lane,
    output logic                            ser_load_en,
    output logic                            ser_rst,
    output logic                            clk_replica_sel,
    output logic                            locked_status
);
    import sttlm_pkg::*;

    sttlm_ctrl_t     ctrl_reg;
    logic [15:0]     codes01_reg;
    logic [15:0]     code2_frc_reg;
    logic [7:0]      lock_wait_reg;
    logic [7:0]      unlock_wait_reg;
    sttlm_lock_t     lock_st_reg;
    logic [7:0]      wait_cnt_reg;
    logic [7:0]      lock_count_reg;
    logic [6:0]      prbs_reg;
    logic [29:0]     prbs_word_reg;
    logic [1:0]      hold_cnt_reg;
    logic [7:0]      idx;
    logic            mapped;
    logic            wr_en;
    logic [15:0]     rd_val;
    logic            prbs_run;
    logic [1:0]      hold_len;
    logic [36:0]     prbs_adv;
    logic [7:0]      lane0_code;
    logic [7:0]      lane1_code;
    logic [7:0]      lane2_code;
    logic            force_high;
    logic            force_low;

    assign lane0_code = codes01_reg[LANE_W-1:0];
    assign lane1_code = codes01_reg[2*LANE_W-1:LANE_W];
    assign lane2_code = code2_frc_reg[LANE_W-1:0];
    assign force_high = code2_frc_reg[FORCE_HIGH_BIT];
    assign force_low  = code2_frc_reg[FORCE_LOW_BIT];

    // APB decode; zero wait states, data latched in the setup cycle
    assign idx     = apb_req.paddr[IDX_MSB:IDX_LSB];
    assign pready  = 1'b1;
    assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite && mapped;
    assign pslverr = apb_req.psel && apb_req.penable && !mapped;

    always_comb begin
        mapped = (apb_req.paddr[ADDR_W-1:IDX_MSB+1] == '0)
              && (apb_req.paddr[IDX_LSB-1:0] == '0);
        rd_val = REG_RESET;
        case (idx)
            IDX_TX_CONFIG: begin
                rd_val[LOAD_EN_STATUS_BIT] = ser_load_en;
            end
            IDX_LOCK_STATUS: begin
                rd_val[LANE_W-1:0]      = lock_count_reg;
                rd_val[LOCK_FLAG_BIT]   = pll_lock_raw;
                rd_val[LOCK_STATUS_BIT] = locked_status;
            end
            IDX_LOCK_WAIT:      rd_val = {unlock_wait_reg, lock_wait_reg};
            IDX_TEST_CONTROL:   rd_val = ctrl_reg;
            IDX_TEST_CODES01:   rd_val = codes01_reg;
            IDX_TEST_CODE2_FRC: rd_val = code2_frc_reg;
            default:            mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (apb_req.psel && !apb_req.penable) begin
            prdata <= {16'h0000, rd_val};
        end
    end

    // Software registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg        <= REG_RESET;
            codes01_reg     <= REG_RESET;
            code2_frc_reg   <= REG_RESET;
            lock_wait_reg   <= BYTE_ZERO;
            unlock_wait_reg <= BYTE_ZERO;
        end else if (wr_en) begin
            case (idx)
                IDX_TEST_CONTROL:   ctrl_reg      <= apb_req.pwdata[15:0] & CTRL_WMASK;
                IDX_TEST_CODES01:   codes01_reg   <= apb_req.pwdata[15:0];
                IDX_TEST_CODE2_FRC: code2_frc_reg <= apb_req.pwdata[15:0] & CODE2_WMASK;
                IDX_LOCK_WAIT: begin
                    lock_wait_reg   <= apb_req.pwdata[7:0];
                    unlock_wait_reg <= apb_req.pwdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Lock monitor; a wait of 0 behaves as 1 sample
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lock_st_reg    <= UNLOCKED_STATE;
            wait_cnt_reg   <= BYTE_ZERO;
            lock_count_reg <= BYTE_ZERO;
        end else begin
            case (lock_st_reg)
                UNLOCKED_STATE: begin
                    if (!pll_lock_raw) begin
                        wait_cnt_reg <= BYTE_ZERO;
                    end else if ({1'b0, wait_cnt_reg} + 9'd1 >= {1'b0, lock_wait_reg}) begin
                        lock_st_reg    <= LOCKED_STATE;
                        wait_cnt_reg   <= BYTE_ZERO;
                        lock_count_reg <= lock_count_reg + BYTE_ONE;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg + BYTE_ONE;
                    end
                end
                LOCKED_STATE: begin
                    if (pll_lock_raw) begin
                        wait_cnt_reg <= BYTE_ZERO;
                    end else if ({1'b0, wait_cnt_reg} + 9'd1 >= {1'b0, unlock_wait_reg}) begin
                        lock_st_reg  <= UNLOCKED_STATE;
                        wait_cnt_reg <= BYTE_ZERO;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg + BYTE_ONE;
                    end
                end
                default: lock_st_reg <= UNLOCKED_STATE;
            endcase
        end
    end

    assign locked_status = (lock_st_reg == LOCKED_STATE);

    // Load enable, force low has priority
    assign ser_load_en = force_low ? 1'b0 : (force_high ? 1'b1 : locked_status);
    // Serializer held in reset while load enable is low
    assign ser_rst = !ser_load_en;
    assign clk_replica_sel = force_low;

    // Single lane from test bit or master configuration
    assign single_lane = (ctrl_reg.test_en && ctrl_reg.single_lane) || outer_master;

    // Thirty steps of x^7+x^6+1 per word
    function automatic logic [36:0] prbs_step(input logic [6:0] seed);
        logic [6:0]  s;
        logic [29:0] bits;
        logic        fb;
        s    = seed;
        bits = '0;
        fb   = 1'b0;
        for (int i = 0; i < SER_W; i++) begin
            fb      = s[PRBS_TAP_A] ^ s[PRBS_TAP_B];
            s       = {s[5:0], fb};
            bits[i] = fb;
        end
        return {s, bits};
    endfunction : prbs_step

    // Rate field only acts while the generator is in use
    assign prbs_run = ctrl_reg.test_en && ctrl_reg.prbs_sel;
    assign prbs_adv = prbs_step(prbs_reg);

    always_comb begin
        case (ctrl_reg.rate)
            RATE_400: hold_len = HOLD_400;
            RATE_600: hold_len = HOLD_600;
            default:  hold_len = HOLD_1200;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prbs_reg      <= PRBS_SEED;
            prbs_word_reg <= '0;
            hold_cnt_reg  <= '0;
        end else if (prbs_run && ctrl_reg.rate == RATE_RESET) begin
            prbs_reg      <= PRBS_SEED;
            prbs_word_reg <= '0;
            hold_cnt_reg  <= '0;
        end else if (prbs_run) begin
            if (hold_cnt_reg == '0) begin
                prbs_reg      <= prbs_adv[36:30];
                prbs_word_reg <= prbs_adv[29:0];
                hold_cnt_reg  <= hold_len;
            end else begin
                hold_cnt_reg <= hold_cnt_reg - 2'd1;
            end
        end
    end

    // Pattern mux into registered encoder and serializer words
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enc_word         <= '0;
            ser_raw_word     <= '0;
            enc_ctrl_sym_sel <= '0;
            enc_bypass       <= 1'b0;
        end else begin
            enc_ctrl_sym_sel <= ctrl_reg.ctrl_sym_sel;
            enc_bypass       <= ctrl_reg.bypass;
            if (!ctrl_reg.test_en) begin
                enc_word     <= data_unit_word;
                ser_raw_word <= {PAD_ZERO, data_unit_word[23:16], PAD_ZERO,
                                 data_unit_word[15:8], PAD_ZERO, data_unit_word[7:0]};
            end else if (ctrl_reg.prbs_sel) begin
                enc_word     <= prbs_word_reg[WORD_W-1:0];
                ser_raw_word <= prbs_word_reg;
            end else begin
                // Constant codes replace the data unit
                enc_word     <= {lane2_code, lane1_code, lane0_code};
                // Pads extend codes to serializer width
                ser_raw_word <= {ctrl_reg.lane2_pad_bits, lane2_code,
                                 ctrl_reg.lane1_pad_bits, lane1_code,
                                 ctrl_reg.lane0_pad_bits, lane0_code};
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    lock_hold_low_a: assert property (
        (lock_st_reg == UNLOCKED_STATE && !pll_lock_raw) |=> !locked_status)
        else $error("locked without raw lock flag");
    lock_hold_high_a: assert property (
        (lock_st_reg == LOCKED_STATE && pll_lock_raw) |=> locked_status)
        else $error("unlocked while raw lock flag high");
    wait_restart_a: assert property (
        (pll_lock_raw == (lock_st_reg == LOCKED_STATE)) |=> wait_cnt_reg == BYTE_ZERO)
        else $error("wait counter not restarted");
    lock_count_a: assert property (
        $rose(locked_status) |-> lock_count_reg == $past(lock_count_reg) + BYTE_ONE)
        else $error("lock counter missed an entry");
    force_low_a: assert property (
        force_low |-> !ser_load_en && ser_rst && clk_replica_sel)
        else $error("force low not honoured");
    force_high_a: assert property (
        (force_high && !force_low) |-> ser_load_en)
        else $error("force high not honoured");
    load_follow_a: assert property (
        (!force_high && !force_low) |-> ser_load_en == (lock_st_reg == LOCKED_STATE))
        else $error("load enable not following lock");
    prbs_reset_a: assert property (
        (prbs_run && ctrl_reg.rate == RATE_RESET) |=> prbs_reg == PRBS_SEED)
        else $error("generator not held in reset");
    code_path_a: assert property (
        (ctrl_reg.test_en && !ctrl_reg.prbs_sel) |=>
            enc_word == $past({code2_frc_reg[7:0], codes01_reg}))
        else $error("test codes not applied");
    normal_path_a: assert property (
        !ctrl_reg.test_en |=> enc_word == $past(data_unit_word))
        else $error("data unit word not passed");
    prbs_path_a: assert property (
        (ctrl_reg.test_en && ctrl_reg.prbs_sel) |=> ser_raw_word == $past(prbs_word_reg))
        else $error("generator word not applied");
    single_lane_a: assert property (
        !outer_master |-> single_lane == (ctrl_reg.test_en && ctrl_reg.single_lane))
        else $error("single lane outside test mode");
    outer_master_a: assert property (
        outer_master |-> single_lane)
        else $error("outer master without single lane");
    // Rate must be steady too, else the hold count still carries the old period
    rate_hold_a: assert property (
        (prbs_run && ctrl_reg.rate == RATE_400 && $stable(ctrl_reg.rate)
            && $changed(prbs_word_reg)) |=> $stable(prbs_word_reg))
        else $error("slow rate word not held");
    prbs_idle_a: assert property (
        !prbs_run |=> $stable(prbs_reg))
        else $error("generator ran outside its mode");
    bypass_path_a: assert property (
        ctrl_reg.bypass |=> enc_bypass)
        else $error("bypass not passed on");
    pad_path_a: assert property (
        (ctrl_reg.test_en && !ctrl_reg.prbs_sel) |=>
            ser_raw_word[SER_W-1:WORD_W+4] == $past(ctrl_reg.lane2_pad_bits))
        else $error("lane 2 pad bits not applied");
    sym_sel_a: assert property (
        1'b1 |=> enc_ctrl_sym_sel == $past(ctrl_reg.ctrl_sym_sel))
        else $error("control symbol selects not passed on");

    lock_rise_c: cover property ($rose(locked_status));
    lock_fall_c: cover property ($fell(locked_status));
    prbs_slow_c: cover property (prbs_run && ctrl_reg.rate == RATE_400 ##3 prbs_run);
    force_low_c: cover property (force_low ##1 !force_low);
    bypass_code_c: cover property (ctrl_reg.bypass && ctrl_reg.test_en && !ctrl_reg.prbs_sel);
endmodule : sttlm_top
`default_nettype wire

// *** verification/sttlm_rx_model.sv ***
/*
 Behavioural model of the serial link receiver fed by the transmitter.
 Assumes every input is synchronous to clk_sys. The model captures each word
 that the serializer would load and shows it on rx_word.
*/
`timescale 1ns/1ps
`default_nettype none
module sttlm_rx_model (
    // Clock
    input  wire logic        clk_sys,
    // Serializer side
    input  wire logic        ser_load_en,
    input  wire logic        enc_bypass,
    input  wire logic [29:0] ser_raw_word,
    input  wire logic [23:0] enc_word,
    // Received word
    output logic      [29:0] rx_word
);
    always_ff @(posedge clk_sys) begin
        if (ser_load_en) begin
            rx_word <= enc_bypass ? ser_raw_word : {6'h00, enc_word};
        end
    end
endmodule : sttlm_rx_model
`default_nettype wire

// *** verification/sttlm_top_tb.sv ***
/*
 Self-checking testbench for the transmitter test and lock monitor block.
 Assumes the package register map, a zero-wait APB slave and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sttlm_top_tb;
    import sttlm_pkg::*;
    logic           clk_sys = 1'b0;
    logic           sys_rst = 1'b1;
    sttlm_apb_req_t apb_req = '0;
    logic           pll_lock_raw = 1'b0;
    logic           outer_master = 1'b0;
    logic [23:0]    data_unit_word = 24'h000000;
    logic           pready, pslverr, enc_bypass, single_lane;
    logic           ser_load_en, ser_rst, clk_replica_sel, locked_status;
    logic [31:0]    prdata;
    logic [23:0]    enc_word, c, dw, prev;
    logic [2:0]     enc_ctrl_sym_sel;
    logic [29:0]    ser_raw_word, rx_word, exp_raw;
    logic [15:0]    ctrl;
    logic [32:0]    exp_q[$];
    logic [15:0]    rate_ctrl[5] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0009};
    int             rate_chg[5] = '{30, 10, 15, 0, 0};
    int             fail_count = 0;
    int             num_checks = 0;
    int             cnt;
    integer         seed;

    sttlm_top i_sttlm_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(apb_req),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .pll_lock_raw(pll_lock_raw),
        .outer_master(outer_master), .data_unit_word(data_unit_word), .enc_word(enc_word),
        .enc_ctrl_sym_sel(enc_ctrl_sym_sel), .enc_bypass(enc_bypass),
        .ser_raw_word(ser_raw_word), .single_lane(single_lane), .ser_load_en(ser_load_en),
        .ser_rst(ser_rst), .clk_replica_sel(clk_replica_sel), .locked_status(locked_status));

    sttlm_rx_model i_sttlm_rx_model (.clk_sys(clk_sys), .ser_load_en(ser_load_en),
        .enc_bypass(enc_bypass), .ser_raw_word(ser_raw_word), .enc_word(enc_word),
        .rx_word(rx_word));

    always #10 clk_sys = ~clk_sys;

    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    // One APB transfer; starts after an edge, holds until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do @(posedge clk_sys); while (pready !== 1'b1);
        apb_req <= '0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h00000000);
    endtask : rd

    // Read results are compared against the oldest note
    always @(posedge clk_sys) begin
        if (apb_req.psel && apb_req.penable && pready === 1'b1 && !apb_req.pwrite) begin
            if (exp_q.size() == 0) check(1'b0, "unexpected read");
            else check({pslverr, prdata} === exp_q.pop_front(), "read data or error");
        end
    end

    // Whole run is a few hundred cycles
    initial begin
        #200000;
        fail_count++;
        close_out();
    end

    initial begin
        seed = 32'hA7EB1C0F;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 check(ser_load_en === 1'b0 && ser_rst === 1'b1, "reset load enable");
        // Hole at 0x54 answers with a slave error
        foreach (rate_chg[i]) rd(12'h050 + 12'(i) * 12'h004, {i == 1, 32'h0});
        rd(12'h064, 33'h0);
        rd(12'h068, 33'h0);
        rd(12'h070, {1'b1, 32'h0});
        // Lock after 3 high samples, unlock after 2 low ones
        apb(1'b1, 12'h05C, 32'h00000203);
        rd(12'h05C, 33'h0203);
        @(posedge clk_sys);
        pll_lock_raw <= 1'b1;
        repeat (2) @(posedge clk_sys);
        pll_lock_raw <= 1'b0;
        @(posedge clk_sys);
        pll_lock_raw <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 check(locked_status === 1'b0, "lock too early");
        @(posedge clk_sys);
        #1 check(locked_status === 1'b1 && ser_load_en === 1'b1, "lock missed");
        rd(12'h058, 33'h0301);
        rd(12'h050, 33'h1000);
        @(posedge clk_sys);
        pll_lock_raw <= 1'b0;
        @(posedge clk_sys);
        #1 check(locked_status === 1'b1, "unlock too early");
        @(posedge clk_sys);
        #1 check(locked_status === 1'b0 && ser_load_en === 1'b0, "unlock missed");
        apb(1'b1, 12'h068, 32'h00000100);
        #1 check(ser_load_en === 1'b1 && ser_rst === 1'b0, "force high");
        apb(1'b1, 12'h068, 32'h00000300);
        #1 check(!ser_load_en && ser_rst && clk_replica_sel, "force low");
        rd(12'h050, 33'h0);
        // Random codes and data unit word
        c = 24'($random(seed));
        dw = 24'($random(seed));
        @(posedge clk_sys);
        data_unit_word <= dw;
        apb(1'b1, 12'h064, {16'h0000, c[15:0]});
        apb(1'b1, 12'h068, {22'h000000, 2'b01, c[23:16]});
        apb(1'b1, 12'h060, 32'h00000001);
        repeat (2) @(posedge clk_sys);
        #1 check(enc_word === c, "test codes");
        apb(1'b1, 12'h060, 32'h00000000);
        repeat (2) @(posedge clk_sys);
        #1 check(enc_word === dw, "data unit word");
        ctrl = {1'b1, 3'($random(seed)), 6'($random(seed)), 6'b100001};
        apb(1'b1, 12'h060, {16'h0000, ctrl});
        repeat (3) @(posedge clk_sys);
        exp_raw = {ctrl[11:10], c[23:16], ctrl[9:8], c[15:8], ctrl[7:6], c[7:0]};
        #1 check(ser_raw_word === exp_raw && rx_word === exp_raw, "padded codes");
        check(enc_ctrl_sym_sel === ctrl[14:12] && enc_bypass === 1'b1, "symbol sel");
        rd(12'h060, {18'h0, ctrl[14:0]});
        apb(1'b1, 12'h060, 32'h00000020);
        repeat (3) @(posedge clk_sys);
        exp_raw = {2'b00, dw[23:16], 2'b00, dw[15:8], 2'b00, dw[7:0]};
        #1 check(ser_raw_word === exp_raw && rx_word === exp_raw, "bypass data");
        apb(1'b1, 12'h060, 32'h00000004);
        #1 check(single_lane === 1'b0, "single lane outside test");
        apb(1'b1, 12'h060, 32'h00000005);
        #1 check(single_lane === 1'b1, "single lane in test");
        apb(1'b1, 12'h060, 32'h00000000);
        @(posedge clk_sys);
        outer_master <= 1'b1;
        @(posedge clk_sys);
        #1 check(single_lane === 1'b1, "outer master single lane");
        @(posedge clk_sys);
        outer_master <= 1'b0;
        // Word change count over 30 cycles for each rate setting
        foreach (rate_ctrl[i]) begin
            apb(1'b1, 12'h060, {16'h0000, rate_ctrl[i]});
            repeat (4) @(posedge clk_sys);
            #1 prev = enc_word;
            cnt = 0;
            repeat (30) begin
                @(posedge clk_sys);
                #1 if (enc_word !== prev) cnt++;
                prev = enc_word;
            end
            check(cnt == rate_chg[i], "pattern word rate");
            check(i != 3 || enc_word === 24'h000000, "generator held");
        end
        close_out();
    end
endmodule : sttlm_top_tb
`default_nettype wire
